/* inc/socr_pkg.sv */
package socr_pkg;

	// Byte address of bits 7-0 of each register; higher bytes follow.
	localparam logic [5:0] PROTO_ADDR = 6'h0C;
	localparam logic [5:0] CONTENT_ADDR = 6'h10;

	// Field positions inside the output protocol register.
	localparam int MODE_POS = 0;
	localparam int SYNC_CLK_POS = 6;
	localparam int ROLE_POS = 8;
	localparam int GPO_POS = 12;

	// Field positions inside the output frame content register.
	localparam int PAT_POS = 0;
	localparam int PAR_POS = 3;
	localparam int INCLUDE_RANGE_SETTING_POS = 8;
	localparam int IN_AL_POS = 10;
	localparam int SUP_AL_POS = 12;
	localparam int DEV_POS = 14;

	// Output mode codes; the invalid code is never to be programmed.
	localparam logic [1:0] MODE_SYNC = 2'h3;
	localparam logic [1:0] MODE_BAD = 2'h2;

	// Result width and the frame word that carries the left-aligned frame.
	localparam int RESULT_W = 14;
	localparam int FRAME_W = 32;

	// Test patterns, most significant bit shifted out first.
	localparam logic [13:0] PAT_ZEROS = 14'h0000;
	localparam logic [13:0] PAT_ONES = 14'h3FFF;
	localparam logic [13:0] PAT_ALT1 = 14'h1555;
	localparam logic [13:0] PAT_ALT2 = 14'h0CCC;

	// Role of the second output pin.
	typedef enum logic [1:0] {
		ROLE_TRI = 2'h0,
		ROLE_ALARM = 2'h1,
		ROLE_GPO = 2'h2,
		ROLE_LANE = 2'h3
	} socr_role_e;

	// Writable fields of the output protocol register.
	typedef struct packed {
		logic general_output_value;
		socr_role_e second_pin_role;
		logic sync_clock_source;
		logic [1:0] output_mode;
	} socr_proto_s;

	// Writable fields of the output frame content register.
	typedef struct packed {
		logic include_device_address;
		logic [1:0] include_supply_alarm;
		logic [1:0] include_input_alarm;
		logic include_range_setting;
		logic parity_enable;
		logic [2:0] data_pattern;
	} socr_content_s;

	// Reset values of both registers.
	localparam socr_proto_s PROTO_RST = '{1'h0, ROLE_TRI, 1'h0, 2'h0};
	localparam socr_content_s CONTENT_RST = '{1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 3'h0};

endpackage

/* hdl/socr_frame_build.sv */
`timescale 1ns/1ns
// Builds the left-aligned output frame and its length from the content settings.
module socr_frame_build (
	// Settings.
	input wire socr_pkg::socr_content_s content,
	// Frame sources.
	input wire logic [13:0] conv_result,
	input wire logic [3:0] device_address,
	input wire logic [3:0] range_setting,
	input wire logic [1:0] supply_alarm,
	input wire logic [1:0] input_alarm,
	// Frame.
	output logic [31:0] frame_bits,
	output logic [5:0] frame_len
);

	// Places a left-aligned value at the current fill position.
	function automatic logic [31:0] put(input logic [31:0] acc, input logic [31:0] v,
		input logic [5:0] at);
		return acc | (v >> at);
	endfunction

	// Data value first, then address, alarm flags, range and parity bits.
	always_comb begin
		logic [13:0] data;
		logic adc_par;
		data = conv_result;
		frame_bits = 32'h0;
		frame_len = 6'h0;
		adc_par = 1'h0;
		unique case (content.data_pattern) // RL13
			3'h4: data = socr_pkg::PAT_ZEROS;
			3'h5: data = socr_pkg::PAT_ONES;
			3'h6: data = socr_pkg::PAT_ALT1;
			3'h7: data = socr_pkg::PAT_ALT2;
			default: data = conv_result;
		endcase
		frame_bits = {data, 18'h0};
		frame_len = 6'(socr_pkg::RESULT_W);
		adc_par = ^data;
		// RL15
		if (content.include_device_address) begin
			frame_bits = put(frame_bits, {device_address, 28'h0}, frame_len);
			frame_len = frame_len + 6'h4;
		end
		// Bit 0 of each include pair selects the high flag, bit 1 the low flag.
		for (int i = 0; i < 2; i++) begin
			if (content.include_supply_alarm[i]) begin
				frame_bits = put(frame_bits, {supply_alarm[i], 31'h0}, frame_len);
				frame_len = frame_len + 6'h1;
			end
		end
		for (int i = 0; i < 2; i++) begin
			if (content.include_input_alarm[i]) begin
				frame_bits = put(frame_bits, {input_alarm[i], 31'h0}, frame_len);
				frame_len = frame_len + 6'h1;
			end
		end
		if (content.include_range_setting) begin
			frame_bits = put(frame_bits, {range_setting, 28'h0}, frame_len);
			frame_len = frame_len + 6'h4;
		end
		// The frame parity is taken before the result parity joins the frame.
		if (content.parity_enable) begin // RL14
			frame_bits = put(frame_bits, {^frame_bits, 31'h0}, frame_len + 6'h1);
			frame_bits = put(frame_bits, {adc_par, 31'h0}, frame_len);
			frame_len = frame_len + 6'h2;
		end
	end

endmodule

/* hdl/socr_pin_route.sv */
`timescale 1ns/1ns
// Chooses what the second output pin carries for the applied role.
module socr_pin_route (
	// Settings.
	input wire socr_pkg::socr_role_e role,
	input wire logic general_output_value,
	// Pin sources.
	input wire logic alarm_level,
	input wire logic second_lane_data,
	// Pin.
	output logic pin_out,
	output logic pin_oe,
	output logic two_lane
);

	// Each role decides drive, value and lane count together.
	always_comb begin
		pin_out = 1'h0;
		pin_oe = 1'h1;
		two_lane = 1'h0;
		unique case (role) // RL4
			socr_pkg::ROLE_TRI: pin_oe = 1'h0;
			socr_pkg::ROLE_ALARM: pin_out = alarm_level;
			socr_pkg::ROLE_GPO: pin_out = general_output_value; // RL3
			socr_pkg::ROLE_LANE: begin
				pin_out = second_lane_data;
				two_lane = 1'h1;
			end
		endcase
	end

endmodule

/* hdl/socr_serial_output_regs.sv */
`timescale 1ns/1ns
// Operation
// RL1 - Protocol register at bytes 0Ch to 0Fh.
// RL2 - Reserved protocol bits read zero, ignore writes.
// RL3 - Bit 12 drives the general output pin.
// RL4 - Bits 9-8 pick second pin role.
// RL5 - Bit 6 picks external or internal clock.
// RL6 - Clock pick matters only in sync mode.
// RL7 - Mode 0x follows input-side polarity and phase.
// RL8 - Host never programs output mode 10b.
// RL9 - Mode 11b uses source-synchronous protocol.
// RL10 - Power-on-only fields survive application reset.
// RL11 - Content register at bytes 10h to 13h.
// RL12 - Content register holds include, parity, pattern fields.
// RL13 - Pattern field selects result or test pattern.
// RL14 - Parity adds result and frame parity bits.
// RL15 - Includes insert address, range, alarm flags.
// RL16 - Input protocol code gives polarity and phase.
// RL17 - Byte writes touch one lane, skip reserved.
// RL18 - Protocol changes apply at a frame boundary.
module socr_serial_output_regs (
	// Clock and resets; sys_rst is the power-on reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic app_rst,
	// Byte register port from the serial programming engine.
	input wire logic [5:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Frame engine side.
	input wire logic frame_boundary,
	input wire logic [1:0] input_clock_phase_select,
	input wire logic [13:0] conv_result,
	input wire logic [3:0] device_address,
	input wire logic [3:0] range_setting,
	input wire logic [1:0] supply_alarm,
	input wire logic [1:0] input_alarm,
	input wire logic alarm_level,
	input wire logic second_lane_data,
	// Applied output protocol.
	output logic out_cpol,
	output logic out_cpha,
	output logic out_sync_protocol,
	output logic out_clk_internal,
	output logic two_lane,
	// Frame for the shift engine.
	output logic [31:0] frame_bits,
	output logic [5:0] frame_len,
	// Second output pin.
	output logic second_pin_out,
	output logic second_pin_oe
);

	// Registers as software sees them.
	socr_pkg::socr_proto_s proto;
	socr_pkg::socr_content_s content;
	// Copies that the frame side uses, refreshed only between frames.
	socr_pkg::socr_proto_s act_proto;
	socr_pkg::socr_content_s act_content;
	// Write byte moved to its lane within a 32-bit word.
	logic [31:0] wide;
	// Register selects.
	logic hit_proto;
	logic hit_content;
	// Read words with reserved bits forced to zero.
	logic [31:0] proto_word;
	logic [31:0] content_word;
	// Outputs of the two helpers.
	logic [31:0] next_frame_bits;
	logic [5:0] next_frame_len;
	logic next_pin_out;
	logic next_pin_oe;
	logic next_two_lane;

	// True when the addressed byte is the lane holding a field position.
	function automatic logic lane_is(input logic [1:0] lane, input int pos);
		return lane == 2'(pos / 8);
	endfunction

	// Address decode: the upper address bits pick the register.
	assign hit_proto = reg_addr[5:2] == socr_pkg::PROTO_ADDR[5:2]; // RL1
	assign hit_content = reg_addr[5:2] == socr_pkg::CONTENT_ADDR[5:2]; // RL11
	assign wide = 32'(reg_wdata) << {reg_addr[1:0], 3'h0};

	// Read words; only the writable fields are placed, so the rest read zero.
	always_comb begin
		proto_word = 32'h0; // RL2
		proto_word[socr_pkg::MODE_POS +: 2] = proto.output_mode;
		proto_word[socr_pkg::SYNC_CLK_POS] = proto.sync_clock_source;
		proto_word[socr_pkg::ROLE_POS +: 2] = proto.second_pin_role;
		proto_word[socr_pkg::GPO_POS] = proto.general_output_value;
		content_word = 32'h0;
		content_word[socr_pkg::PAT_POS +: 3] = content.data_pattern; // RL12
		content_word[socr_pkg::PAR_POS] = content.parity_enable;
		content_word[socr_pkg::INCLUDE_RANGE_SETTING_POS] = content.include_range_setting;
		content_word[socr_pkg::IN_AL_POS +: 2] = content.include_input_alarm;
		content_word[socr_pkg::SUP_AL_POS +: 2] = content.include_supply_alarm;
		content_word[socr_pkg::DEV_POS] = content.include_device_address;
	end

	// Protocol register. Mode and clock source clear only on power-on reset.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			proto <= socr_pkg::PROTO_RST;
		end else begin
			if (app_rst) begin // RL10
				proto.general_output_value <= socr_pkg::PROTO_RST.general_output_value;
				proto.second_pin_role <= socr_pkg::PROTO_RST.second_pin_role;
			end else if (reg_wr && hit_proto && lane_is(reg_addr[1:0], socr_pkg::ROLE_POS)) begin
				// RL17
				proto.second_pin_role <= socr_pkg::socr_role_e'(wide[socr_pkg::ROLE_POS +: 2]);
				proto.general_output_value <= wide[socr_pkg::GPO_POS];
			end
			if (reg_wr && hit_proto && lane_is(reg_addr[1:0], socr_pkg::MODE_POS)) begin
				// The invalid mode code is stored as written; the host avoids it.
				proto.output_mode <= wide[socr_pkg::MODE_POS +: 2]; // RL8
				proto.sync_clock_source <= wide[socr_pkg::SYNC_CLK_POS];
			end
		end
	end

	// Content register. Only the parity enable survives application reset.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			content <= socr_pkg::CONTENT_RST;
		end else begin
			if (app_rst) begin // RL10
				content.data_pattern <= socr_pkg::CONTENT_RST.data_pattern;
				content.include_range_setting <= socr_pkg::CONTENT_RST.include_range_setting;
				content.include_input_alarm <= socr_pkg::CONTENT_RST.include_input_alarm;
				content.include_supply_alarm <= socr_pkg::CONTENT_RST.include_supply_alarm;
				content.include_device_address <= socr_pkg::CONTENT_RST.include_device_address;
			end else if (reg_wr && hit_content) begin
				// RL17
				if (lane_is(reg_addr[1:0], socr_pkg::PAT_POS)) begin
					content.data_pattern <= wide[socr_pkg::PAT_POS +: 3];
				end
				if (lane_is(reg_addr[1:0], socr_pkg::INCLUDE_RANGE_SETTING_POS)) begin
					content.include_range_setting <= wide[socr_pkg::INCLUDE_RANGE_SETTING_POS];
					content.include_input_alarm <= wide[socr_pkg::IN_AL_POS +: 2];
					content.include_supply_alarm <= wide[socr_pkg::SUP_AL_POS +: 2];
					content.include_device_address <= wide[socr_pkg::DEV_POS];
				end
			end
			if (reg_wr && hit_content && lane_is(reg_addr[1:0], socr_pkg::PAR_POS)) begin
				content.parity_enable <= wide[socr_pkg::PAR_POS];
			end
		end
	end

	// Read data is registered; unmapped addresses read zero.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (hit_proto) begin
				reg_rdata <= 8'(proto_word >> {reg_addr[1:0], 3'h0});
			end else if (hit_content) begin
				reg_rdata <= 8'(content_word >> {reg_addr[1:0], 3'h0});
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// Settings move to the frame side only between frames, so a frame in
	// flight never sees a half-changed protocol, pin role or layout.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			act_proto <= socr_pkg::PROTO_RST;
			act_content <= socr_pkg::CONTENT_RST;
		end else if (frame_boundary) begin // RL18
			act_proto <= proto;
			act_content <= content;
		end
	end

	// Frame assembly from the applied content settings.
	socr_frame_build u_frame (
		.content(act_content),
		.conv_result(conv_result),
		.device_address(device_address),
		.range_setting(range_setting),
		.supply_alarm(supply_alarm),
		.input_alarm(input_alarm),
		.frame_bits(next_frame_bits),
		.frame_len(next_frame_len)
	);

	// Second pin routing from the applied role.
	socr_pin_route u_pin (
		.role(act_proto.second_pin_role),
		.general_output_value(act_proto.general_output_value),
		.alarm_level(alarm_level),
		.second_lane_data(second_lane_data),
		.pin_out(next_pin_out),
		.pin_oe(next_pin_oe),
		.two_lane(next_two_lane)
	);

	// Applied protocol. Only mode 11b leaves the input-side clocking; the
	// clock source only means something there, so it reads low elsewhere.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			out_cpol <= 1'h0;
			out_cpha <= 1'h0;
			out_sync_protocol <= 1'h0;
			out_clk_internal <= 1'h0;
		end else if (act_proto.output_mode == socr_pkg::MODE_SYNC) begin // RL9
			out_cpol <= 1'h0;
			out_cpha <= 1'h0;
			out_sync_protocol <= 1'h1;
			out_clk_internal <= act_proto.sync_clock_source; // RL5
		end else begin
			out_cpol <= input_clock_phase_select[1]; // RL7 RL16
			out_cpha <= input_clock_phase_select[0];
			out_sync_protocol <= 1'h0;
			out_clk_internal <= 1'h0; // RL6
		end
	end

	// Frame and pin outputs, one flop stage after the helpers.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			frame_bits <= 32'h0;
			frame_len <= 6'h0;
			second_pin_out <= 1'h0;
			second_pin_oe <= 1'h0;
			two_lane <= 1'h0;
		end else begin
			frame_bits <= next_frame_bits; // RL13 RL14 RL15
			frame_len <= next_frame_len;
			second_pin_out <= next_pin_out; // RL3
			second_pin_oe <= next_pin_oe; // RL4
			two_lane <= next_two_lane;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	property p_mode_write;
		reg_wr && reg_addr == socr_pkg::PROTO_ADDR |=>
			proto.output_mode == $past(reg_wdata[1:0]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // RL1

	property p_reserved_zero;
		reg_rd && reg_addr == socr_pkg::PROTO_ADDR + 6'h1 |=>
			reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RL2

	property p_gpo_pin;
		act_proto.second_pin_role == socr_pkg::ROLE_GPO |=>
			second_pin_oe && second_pin_out == $past(act_proto.general_output_value);
	endproperty
	a_gpo_pin: assert property (p_gpo_pin) else $error("general output wrong"); // RL3

	property p_tri_pin;
		act_proto.second_pin_role == socr_pkg::ROLE_TRI |=> !second_pin_oe && !two_lane;
	endproperty
	a_tri_pin: assert property (p_tri_pin) else $error("second pin driven"); // RL4

	property p_clk_src;
		act_proto.output_mode == socr_pkg::MODE_SYNC |=>
			out_sync_protocol && out_clk_internal == $past(act_proto.sync_clock_source);
	endproperty
	a_clk_src: assert property (p_clk_src) else $error("sync clock wrong"); // RL5

	property p_clk_ignored;
		act_proto.output_mode != socr_pkg::MODE_SYNC |=> !out_clk_internal && !out_sync_protocol;
	endproperty
	a_clk_ignored: assert property (p_clk_ignored) else $error("clock pick leaked"); // RL6

	property p_follow_input;
		!act_proto.output_mode[1] |=> out_cpol == $past(input_clock_phase_select[1])
			&& out_cpha == $past(input_clock_phase_select[0]);
	endproperty
	a_follow_input: assert property (p_follow_input) else $error("phase not followed"); // RL7

	property p_app_keep;
		app_rst && !reg_wr |=> proto.output_mode == $past(proto.output_mode)
			&& content.parity_enable == $past(content.parity_enable)
			&& proto.second_pin_role == socr_pkg::ROLE_TRI && content.data_pattern == 3'h0;
	endproperty
	a_app_keep: assert property (p_app_keep) else $error("app reset wrong"); // RL10

	property p_content_write;
		reg_wr && !app_rst && reg_addr == socr_pkg::CONTENT_ADDR |=>
			content.data_pattern == $past(reg_wdata[2:0])
			&& content.parity_enable == $past(reg_wdata[3]);
	endproperty
	a_content_write: assert property (p_content_write) else $error("content write lost"); // RL11

	property p_zero_pattern;
		act_content.data_pattern == 3'h4 |=> frame_bits[31:18] == 14'h0;
	endproperty
	a_zero_pattern: assert property (p_zero_pattern) else $error("pattern wrong"); // RL13

	property p_parity_len;
		act_content.parity_enable && act_content[9:4] == 6'h0 |=>
			frame_len == 6'h10 && frame_bits[17] == ^frame_bits[31:18];
	endproperty
	a_parity_len: assert property (p_parity_len) else $error("parity frame wrong"); // RL14

	property p_lane_only;
		reg_wr && !app_rst && reg_addr == socr_pkg::PROTO_ADDR |=>
			proto.second_pin_role == $past(proto.second_pin_role);
	endproperty
	a_lane_only: assert property (p_lane_only) else $error("other lane written"); // RL17

	property p_hold_frame;
		!frame_boundary |=> act_proto == $past(act_proto) && act_content == $past(act_content);
	endproperty
	a_hold_frame: assert property (p_hold_frame) else $error("applied mid frame"); // RL18

	c_sync_mode: cover property (frame_boundary && proto.output_mode == socr_pkg::MODE_SYNC);
	c_two_lane: cover property (two_lane);
	c_parity: cover property (act_content.parity_enable && act_content.include_device_address);

endmodule

/* bench/socr_host_model.sv */
`timescale 1ns/1ns
// Host that programs the register bank one byte per strobe, changing lines just after an edge.
module socr_host_model (
	// Clock.
	input wire logic sys_clk,
	// Read byte returned by the bank.
	input wire logic [7:0] reg_rdata,
	// Byte request lines.
	output logic [5:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata
);
	// Idle lines carry inverted leftovers, so a stale byte can never pass for a fresh one.
	initial begin
		reg_addr = 6'h3F;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_wdata = 8'hA5;
	end

	// Writes one byte; the strobe stands for exactly one edge.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		begin
			// The invalid output mode code is never sent to the protocol byte.
			if (a == socr_pkg::PROTO_ADDR && d[1:0] == socr_pkg::MODE_BAD) begin
				$display("host skipped an invalid output mode write");
			end else begin
				@(posedge sys_clk);
				reg_addr <= a;
				reg_wdata <= d;
				reg_wr <= 1'h1;
				@(posedge sys_clk);
				reg_wr <= 1'h0;
				reg_addr <= ~a;
				reg_wdata <= ~d;
			end
		end
	endtask

	// Reads one byte; the answer is registered, so it is taken one edge after the strobe.
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_rd <= 1'h1;
			@(posedge sys_clk);
			reg_rd <= 1'h0;
			reg_addr <= ~a;
			@(posedge sys_clk);
			d = reg_rdata;
		end
	endtask
endmodule

/* bench/serial_output_config_regs_test.sv */
`timescale 1ns/1ns
// Self-checking bench for the serial output register bank.
module serial_output_config_regs_test;
	// One table row: write a byte, then read a byte back.
	typedef struct packed {
		logic [5:0] wa;
		logic [7:0] wd;
		logic [5:0] ra;
		logic [7:0] exp;
	} socr_row_s;

	logic sys_clk, sys_rst, app_rst, frame_boundary;
	logic [1:0] input_clock_phase_select, supply_alarm, input_alarm;
	logic [13:0] conv_result;
	logic [3:0] device_address, range_setting;
	logic alarm_level, second_lane_data;
	logic [5:0] reg_addr, frame_len;
	logic reg_wr, reg_rd;
	logic [7:0] reg_wdata, reg_rdata, rd_byte;
	logic out_cpol, out_cpha, out_sync_protocol, out_clk_internal, two_lane;
	logic [31:0] frame_bits;
	logic second_pin_out, second_pin_oe;
	logic [25:0] body;
	logic [13:0] pat;
	int fails, tests_run;
	// Expected pin view per role: output enable, two lanes, pin value.
	// The alarm level and the general output value differ, so a swapped route shows.
	logic [2:0] pin_exp [4] = '{3'h0, 3'h5, 3'h4, 3'h7};
	// Reserved bits, byte lanes and unmapped places; later rows prove earlier lanes survive.
	socr_row_s rows [11] = '{
		'{6'h0D, 8'hFF, 6'h0D, 8'h13}, '{6'h0C, 8'h00, 6'h0D, 8'h13},
		'{6'h0C, 8'hFF, 6'h0C, 8'h43}, '{6'h0E, 8'hFF, 6'h0E, 8'h00},
		'{6'h0F, 8'hFF, 6'h0F, 8'h00}, '{6'h10, 8'hFF, 6'h10, 8'h0F},
		'{6'h11, 8'hFF, 6'h11, 8'h7D}, '{6'h12, 8'hFF, 6'h12, 8'h00},
		'{6'h13, 8'hFF, 6'h13, 8'h00}, '{6'h20, 8'hFF, 6'h20, 8'h00},
		'{6'h11, 8'h00, 6'h10, 8'h0F}};

	socr_serial_output_regs dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .app_rst(app_rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.frame_boundary(frame_boundary), .input_clock_phase_select(input_clock_phase_select),
		.conv_result(conv_result), .device_address(device_address),
		.range_setting(range_setting), .supply_alarm(supply_alarm),
		.input_alarm(input_alarm), .alarm_level(alarm_level),
		.second_lane_data(second_lane_data), .out_cpol(out_cpol), .out_cpha(out_cpha),
		.out_sync_protocol(out_sync_protocol), .out_clk_internal(out_clk_internal),
		.two_lane(two_lane), .frame_bits(frame_bits), .frame_len(frame_len),
		.second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe));

	socr_host_model host (
		.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

	// A 50 ns clock.
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Counts every compare and reports a mismatch at once.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			tests_run++;
			if (seen !== exp) begin
				fails++;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask

	// Reads one byte through the host and compares it.
	task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
		begin
			host.rd(a, rd_byte);
			chk({24'h0, rd_byte}, {24'h0, exp});
		end
	endtask

	// Pulses the frame boundary and waits until the outputs show the applied settings.
	task automatic apply;
		begin
			@(posedge sys_clk);
			frame_boundary <= 1'h1;
			@(posedge sys_clk);
			frame_boundary <= 1'h0;
			repeat (2) @(posedge sys_clk);
			#1;
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run;
		begin
			$display("compares %0d mismatches %0d", tests_run, fails);
			if (fails == 0 && tests_run > 0) begin
				$display("NO MISMATCHES");
			end else begin
				$display("MISMATCHES SEEN");
			end
			$finish;
		end
	endtask

	// Cuts a hang short; the run needs far fewer cycles than this.
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		complete_run();
	end

	initial begin
		fails = 0;
		tests_run = 0;
		sys_rst = 1'h1;
		app_rst = 1'h0;
		frame_boundary = 1'h0;
		input_clock_phase_select = 2'h2;
		conv_result = 14'h2A5B;
		device_address = 4'h9;
		range_setting = 4'h6;
		supply_alarm = 2'h1;
		input_alarm = 2'h2;
		alarm_level = 1'h1;
		second_lane_data = 1'h1;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'h0;
		foreach (rows[i]) begin
			host.wr(rows[i].wa, rows[i].wd);
			rchk(rows[i].ra, rows[i].exp);
		end
		$display("register table done");
		// Application reset keeps only the power-on-only fields.
		host.wr(6'h11, 8'h7D);
		@(posedge sys_clk);
		app_rst <= 1'h1;
		@(posedge sys_clk);
		app_rst <= 1'h0;
		rchk(6'h0C, 8'h43);
		rchk(6'h0D, 8'h00);
		rchk(6'h10, 8'h08);
		rchk(6'h11, 8'h00);
		$display("application reset done");
		// The staged sync mode stays invisible until a boundary.
		chk({31'h0, out_sync_protocol}, 32'h0);
		apply();
		chk({31'h0, out_sync_protocol}, 32'h1);
		chk({31'h0, out_clk_internal}, 32'h1);
		chk({30'h0, out_cpol, out_cpha}, 32'h0);
		host.wr(6'h0C, 8'h03);
		apply();
		chk({31'h0, out_clk_internal}, 32'h0);
		host.wr(6'h0C, 8'h40);
		apply();
		chk({30'h0, out_sync_protocol, out_clk_internal}, 32'h0);
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			input_clock_phase_select <= k[1:0];
			repeat (2) @(posedge sys_clk);
			#1;
			chk({30'h0, out_cpol, out_cpha}, k);
		end
		$display("protocol done");
		// Each pin role with the general output value clear, then the general output role with that value set.
		for (int r = 0; r < 4; r++) begin
			host.wr(6'h0D, {6'h00, r[1:0]});
			apply();
			chk({29'h0, second_pin_oe, two_lane, (r == 0) ? 1'h0 : second_pin_out},
				{29'h0, pin_exp[r]});
		end
		host.wr(6'h0D, 8'h12);
		apply();
		chk({31'h0, second_pin_out}, 32'h1);
		$display("pin roles done");
		// Every data pattern code, without parity or inserted fields.
		for (int p = 0; p < 8; p++) begin
			host.wr(6'h10, {5'h00, p[2:0]});
			apply();
			case (p)
				4: pat = socr_pkg::PAT_ZEROS;
				5: pat = socr_pkg::PAT_ONES;
				6: pat = socr_pkg::PAT_ALT1;
				7: pat = socr_pkg::PAT_ALT2;
				default: pat = conv_result;
			endcase
			chk({26'h0, frame_len}, 32'hE);
			chk(frame_bits, {pat, 18'h0});
		end
		host.wr(6'h10, 8'h0B);
		apply();
		chk({26'h0, frame_len}, 32'h10);
		chk(frame_bits, {conv_result, ^conv_result, ^conv_result, 16'h0});
		host.wr(6'h11, 8'h7D);
		apply();
		body = {conv_result, device_address, supply_alarm[0], supply_alarm[1],
			input_alarm[0], input_alarm[1], range_setting};
		chk({26'h0, frame_len}, 32'h1C);
		chk(frame_bits, {body, ^conv_result, ^body, 4'h0});
		$display("frame content done");
		// Power-on reset clears the power-on-only fields as well.
		@(posedge sys_clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'h0;
		rchk(6'h0C, 8'h00);
		rchk(6'h10, 8'h00);
		$display("power-on reset done");
		complete_run();
	end
endmodule
